// File: core/efh_pkg.sv
// Package for the elastic FIFO host controller: timing counts and carrier types
`default_nettype none
package efh_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 20;
   // Minimum strobe HIGH and LOW width at the device pins
   localparam int STROBE_WIDTH_NS = 24;
   localparam int STROBE_CYC = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Master clear HIGH width
   localparam int CLEAR_WIDTH_NS = 24;
   localparam int CLEAR_CYC = (CLEAR_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Master clear to shift-in recovery
   localparam int RECOVERY_NS = 22;
   localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Data hold after the shift-in rising edge
   localparam int HOLD_NS = 41;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   localparam int DATA_W = 4;
   localparam int DEPTH = 16;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      EFH_IDLE = 3'h0,
      EFH_HIGH = 3'h1,
      EFH_LOW = 3'h3,
      EFH_CLEAR = 3'h2,
      EFH_RECOV = 3'h6
   } efh_state_e;

   // Pins driven toward the device
   typedef struct packed {
      logic master_clear;
      logic shift_in;
      logic shift_out;
      logic out_enable;
      logic [DATA_W-1:0] data_inputs;
   } efh_pins_out_s;

   // Pins read back from the device
   typedef struct packed {
      logic input_ready;
      logic output_ready_flag;
      logic [DATA_W-1:0] data_outputs;
   } efh_pins_in_s;
endpackage
`default_nettype wire

// File: core/efh_host.sv
// Host controller that drives an elastic 16x4 FIFO through its handshake pins
// Behaviour
// - Raising shift-in loads the word on the data inputs.
// - Writer must lower shift-in to finish a held shift-in.
// - In burst mode shift-in pulses, three cycles HIGH and at least three LOW, ignore input-ready.
// - Reader must lower shift-out to finish a held shift-out.
`default_nettype none
module efh_host
   import efh_pkg::*;
#(
   parameter int DATA_W_P = efh_pkg::DATA_W
) (
   input wire logic clk,
   input wire logic rst,
   // User side
   input wire logic clear_req,
   input wire logic burst_mode,
   input wire logic wr_valid,
   input wire logic [efh_pkg::DATA_W-1:0] wr_data,
   output logic wr_ready,
   output logic rd_valid,
   output logic [efh_pkg::DATA_W-1:0] rd_data,
   input wire logic rd_ready,
   input wire logic out_en_req,
   // Device side
   output efh_pkg::efh_pins_out_s dev_out,
   input wire efh_pkg::efh_pins_in_s dev_in
);
   import efh_pkg::*;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   efh_pins_in_s sync1_ff, sync2_ff;
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= dev_in;
         sync2_ff <= sync1_ff;
      end
   end

   // ************************************************************
   // Write side: shift-in strobe sequencer
   // ************************************************************
   efh_state_e wst_ff, nxt_wst;
   logic [2:0] wcnt_ff, nxt_wcnt;
   logic si_ff, nxt_si;
   logic mr_ff, nxt_mr;
   logic [DATA_W-1:0] din_ff, nxt_din;
   logic wr_ready_ff, nxt_wr_ready;

   always_comb begin
      nxt_wst = wst_ff;
      nxt_wcnt = wcnt_ff;
      nxt_si = si_ff;
      nxt_mr = mr_ff;
      nxt_din = din_ff;
      nxt_wr_ready = 1'b0;
      case (wst_ff)
         EFH_IDLE: begin
            if (clear_req) begin
               nxt_mr = 1'b1;
               nxt_si = 1'b0;
               nxt_wcnt = 3'(CLEAR_CYC);
               nxt_wst = EFH_CLEAR;
            end else if (wr_valid && !wr_ready_ff && (burst_mode || sync2_ff.input_ready)) begin
               // Flag is a don't-care in burst mode; overflow is dropped by the device
               nxt_si = 1'b1;
               nxt_din = wr_data;
               nxt_wcnt = 3'(STROBE_CYC > HOLD_CYC ? STROBE_CYC : HOLD_CYC);
               nxt_wr_ready = 1'b1;
               nxt_wst = EFH_HIGH;
            end
         end
         EFH_HIGH: begin
            if (wcnt_ff > 3'h1) begin
               nxt_wcnt = wcnt_ff - 3'h1;
            end else begin
               // Always lower the strobe so a held shift-in completes
               nxt_si = 1'b0;
               nxt_wcnt = 3'(STROBE_CYC);
               nxt_wst = EFH_LOW;
            end
         end
         EFH_LOW: begin
            if (wcnt_ff > 3'h1) begin
               nxt_wcnt = wcnt_ff - 3'h1;
            end else begin
               // Flag is resampled only after the two-stage sync has caught up
               nxt_wst = EFH_IDLE;
            end
         end
         EFH_CLEAR: begin
            if (wcnt_ff > 3'h1) begin
               nxt_wcnt = wcnt_ff - 3'h1;
            end else begin
               nxt_mr = 1'b0;
               nxt_wcnt = 3'(RECOVERY_CYC + 2);
               nxt_wst = EFH_RECOV;
            end
         end
         EFH_RECOV: begin
            if (wcnt_ff > 3'h1) begin
               nxt_wcnt = wcnt_ff - 3'h1;
            end else begin
               nxt_wst = EFH_IDLE;
            end
         end
         default: begin
            nxt_wst = EFH_IDLE;
            nxt_si = 1'b0;
            nxt_mr = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wst_ff <= EFH_IDLE;
         wcnt_ff <= 3'h0;
         si_ff <= 1'b0;
         mr_ff <= 1'b0;
         din_ff <= '0;
         wr_ready_ff <= 1'b0;
      end else begin
         wst_ff <= nxt_wst;
         wcnt_ff <= nxt_wcnt;
         si_ff <= nxt_si;
         mr_ff <= nxt_mr;
         din_ff <= nxt_din;
         wr_ready_ff <= nxt_wr_ready;
      end
   end

   // ************************************************************
   // Read side: shift-out strobe sequencer
   // ************************************************************
   efh_state_e rst_st_ff, nxt_rst_st;
   logic [2:0] rcnt_ff, nxt_rcnt;
   logic so_ff, nxt_so;
   logic rd_valid_ff, nxt_rd_valid;
   logic [DATA_W-1:0] rdat_ff, nxt_rdat;
   logic oe_ff, nxt_oe;
   logic [1:0] oe_seen_ff, nxt_oe_seen;

   always_comb begin
      nxt_rst_st = rst_st_ff;
      nxt_rcnt = rcnt_ff;
      nxt_so = so_ff;
      nxt_rd_valid = rd_valid_ff;
      nxt_rdat = rdat_ff;
      nxt_oe = out_en_req;
      nxt_oe_seen = {oe_seen_ff[0], oe_ff};
      if (rd_valid_ff && rd_ready) begin
         nxt_rd_valid = 1'b0;
      end
      case (rst_st_ff)
         EFH_IDLE: begin
            // Sample data only while the flag says it is settled
            if (mr_ff) begin
               nxt_rd_valid = 1'b0;
            end else if (sync2_ff.output_ready_flag && !rd_valid_ff && oe_ff && (&oe_seen_ff)) begin
               // Freshly enabled pins need the enable time plus both sync stages
               nxt_rdat = sync2_ff.data_outputs;
               nxt_rd_valid = 1'b1;
               nxt_so = 1'b1;
               nxt_rcnt = 3'(STROBE_CYC);
               nxt_rst_st = EFH_HIGH;
            end
         end
         EFH_HIGH: begin
            if (rcnt_ff > 3'h1) begin
               nxt_rcnt = rcnt_ff - 3'h1;
            end else begin
               nxt_so = 1'b0;
               nxt_rcnt = 3'(STROBE_CYC + 2);
               nxt_rst_st = EFH_LOW;
            end
         end
         EFH_LOW: begin
            if (rcnt_ff > 3'h1) begin
               nxt_rcnt = rcnt_ff - 3'h1;
            end else begin
               // A LOW flag here means empty; no strobe is sent then
               nxt_rst_st = EFH_IDLE;
            end
         end
         default: begin
            nxt_rst_st = EFH_IDLE;
            nxt_so = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rst_st_ff <= EFH_IDLE;
         rcnt_ff <= 3'h0;
         so_ff <= 1'b0;
         rd_valid_ff <= 1'b0;
         rdat_ff <= '0;
         oe_ff <= 1'b0;
         oe_seen_ff <= 2'h0;
      end else begin
         rst_st_ff <= nxt_rst_st;
         rcnt_ff <= nxt_rcnt;
         so_ff <= nxt_so;
         rd_valid_ff <= nxt_rd_valid;
         rdat_ff <= nxt_rdat;
         oe_ff <= nxt_oe;
         oe_seen_ff <= nxt_oe_seen;
      end
   end

   assign dev_out = '{master_clear: mr_ff, shift_in: si_ff, shift_out: so_ff,
                      out_enable: oe_ff, data_inputs: din_ff};
   assign wr_ready = wr_ready_ff;
   assign rd_valid = rd_valid_ff;
   assign rd_data = rdat_ff;

   // ************************************************************
   // Assertions
   // ************************************************************
   a_si_high_width: assert property (@(posedge clk) disable iff (rst)
      $rose(si_ff) |-> si_ff[*2]) else $error("shift-in high too short");
   a_si_low_width: assert property (@(posedge clk) disable iff (rst)
      $fell(si_ff) |-> !si_ff[*2]) else $error("shift-in low too short");
   a_so_high_width: assert property (@(posedge clk) disable iff (rst)
      $rose(so_ff) |-> so_ff[*2]) else $error("shift-out high too short");
   a_so_ends: assert property (@(posedge clk) disable iff (rst)
      $rose(so_ff) |-> ##[1:4] !so_ff) else $error("shift-out never lowered");
   a_si_ends: assert property (@(posedge clk) disable iff (rst)
      $rose(si_ff) |-> ##[1:5] !si_ff) else $error("shift-in never lowered");
   a_clear_width: assert property (@(posedge clk) disable iff (rst)
      $rose(mr_ff) |-> mr_ff[*2] ##1 !mr_ff) else $error("clear width wrong");
   a_no_si_clear: assert property (@(posedge clk) disable iff (rst)
      mr_ff |-> !si_ff) else $error("shift-in during clear");
   a_flag_gated: assert property (@(posedge clk) disable iff (rst)
      $rose(si_ff) && !$past(burst_mode) |-> $past(sync2_ff.input_ready))
      else $error("shift-in without input ready");
   a_read_gated: assert property (@(posedge clk) disable iff (rst)
      $rose(so_ff) |-> $past(sync2_ff.output_ready_flag)) else $error("read without flag");
   a_data_stable: assert property (@(posedge clk) disable iff (rst)
      si_ff && $past(si_ff) |-> $stable(din_ff)) else $error("data moved under shift-in");
   a_read_enabled: assert property (@(posedge clk) disable iff (rst)
      $rose(so_ff) |-> $past(oe_ff, 2)) else $error("read before data pins enabled");
   c_write: cover property (@(posedge clk) disable iff (rst) $rose(si_ff));
   c_read: cover property (@(posedge clk) disable iff (rst) $rose(so_ff));
   c_burst: cover property (@(posedge clk) disable iff (rst) burst_mode && $rose(si_ff));
   c_clear: cover property (@(posedge clk) disable iff (rst) $rose(mr_ff));
endmodule // efh_host
`default_nettype wire

// File: testbench/efh_dev_model.sv
// Behavioural model of the elastic 16x4 FIFO device seen by the host
`default_nettype none
module efh_dev_model (
   input wire logic master_clear,
   input wire logic shift_in,
   input wire logic shift_out,
   input wire logic out_enable,
   input wire logic [3:0] data_inputs,
   output logic input_ready,
   output logic output_ready_flag,
   output logic [3:0] data_outputs
);
   timeunit 1ns;
   timeprecision 1ps;
   import efh_pkg::*;
   logic [3:0] mem[$];
   logic [3:0] held;
   logic [3:0] front = 4'h0;
   logic took = 1'b0;
   initial begin
      input_ready = 1'b1;
      output_ready_flag = 1'b0;
   end
   // Released pins show the inverse so a stale read cannot pass
   assign data_outputs = out_enable ? front : ~front;
   always @(posedge master_clear) begin
      mem.delete();
      input_ready <= #20 1'b1;
      output_ready_flag <= #20 1'b0;
   end
   always @(posedge shift_in) begin
      took = !master_clear && mem.size() < DEPTH;
      held = data_inputs;
      if (took) input_ready <= #10 1'b0;
   end
   always @(negedge shift_in) if (took) begin
      mem.push_back(held);
      took = 1'b0;
      input_ready <= #30 (mem.size() < DEPTH);
      if (mem.size() == 1) begin
         // Data leads the flag so a cascaded input sees it settled
         front <= #55 held;
         output_ready_flag <= #60 1'b1;
      end
   end
   always @(posedge shift_out) if (mem.size() > 0) output_ready_flag <= #10 1'b0;
   always @(negedge shift_out) if (mem.size() > 0) begin
      void'(mem.pop_front());
      input_ready <= #50 1'b1;
      // A word refused while full and still held in takes the bubble
      if (shift_in && !took && !master_clear) begin
         mem.push_back(held);
         input_ready <= #80 1'b0;
      end
      if (mem.size() > 0) begin
         front <= #55 mem[0];
         output_ready_flag <= #60 1'b1;
      end
   end
   // Shift-out held high while empty: the arriving word is passed straight on
   always @(posedge output_ready_flag) if (shift_out && mem.size() == 1) begin
      void'(mem.pop_front());
      output_ready_flag <= #30 1'b0;
      input_ready <= #50 1'b1;
   end
endmodule // efh_dev_model
`default_nettype wire

// File: testbench/tb.sv
// Self-checking testbench of the elastic FIFO host controller
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import efh_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clear_req = 1'b0;
   logic burst_mode = 1'b0;
   logic wr_valid = 1'b0;
   logic rd_ready = 1'b0;
   logic out_en_req = 1'b0;
   logic [DATA_W-1:0] wr_data = 4'h0;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] dq;
   logic wr_ready, rd_valid, ir, orf;
   efh_pins_out_s dev_out;
   efh_pins_in_s dev_in;
   int fail_count = 0;
   int total_checks = 0;
   always #10 clk = ~clk;
   assign dev_in = '{input_ready: ir, output_ready_flag: orf, data_outputs: dq};
   efh_host i_dut (.clk(clk), .rst(rst), .clear_req(clear_req), .burst_mode(burst_mode),
      .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
      .rd_data(rd_data), .rd_ready(rd_ready), .out_en_req(out_en_req), .dev_out(dev_out),
      .dev_in(dev_in));
   efh_dev_model i_dev (.master_clear(dev_out.master_clear), .shift_in(dev_out.shift_in),
      .shift_out(dev_out.shift_out), .out_enable(dev_out.out_enable),
      .data_inputs(dev_out.data_inputs), .input_ready(ir), .output_ready_flag(orf),
      .data_outputs(dq));
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_word(input logic [3:0] d, input logic take);
      int i;
      wr_data = d;
      wr_valid = 1'b1;
      for (i = 0; i < 20 && wr_ready !== 1'b1; i++) tick(1);
      wr_valid = 1'b0;
      chk({7'h0, wr_ready}, {7'h0, take});
      tick(6);
   endtask
   task automatic rd_word(input logic [3:0] d);
      int i;
      for (i = 0; i < 40 && rd_valid !== 1'b1; i++) tick(1);
      chk({3'h0, rd_valid, rd_data}, {4'h1, d});
      rd_ready = 1'b1;
      tick(1);
      rd_ready = 1'b0;
   endtask
   // Watches that no read is started for n cycles
   task automatic no_read(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         tick(1);
         seen = seen | (rd_valid !== 1'b0) | (dev_out.shift_out !== 1'b0);
      end
      chk({7'h0, seen}, 8'h0);
   endtask
   task automatic do_clear;
      int i;
      clear_req = 1'b1;
      for (i = 0; i < 10 && dev_out.master_clear !== 1'b1; i++) tick(1);
      clear_req = 1'b0;
      chk({7'h0, dev_out.master_clear}, 8'h1);
      tick(8);
      chk({6'h0, ir, orf}, 8'h2);
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_fill_order;
      int k;
      out_en_req = 1'b0;
      for (k = 0; k < DEPTH; k++) wr_word(4'(k) ^ 4'h5, 1'b1);
      wr_word(4'ha, 1'b0);
      burst_mode = 1'b1;
      wr_word(4'hb, 1'b1);
      burst_mode = 1'b0;
      chk({7'h0, ir}, 8'h0);
      out_en_req = 1'b1;
      for (k = 0; k < DEPTH; k++) rd_word(4'(k) ^ 4'h5);
      no_read(30);
      chk({4'h0, dq}, 8'h0a);
      $display("test fill_order done");
   endtask
   task automatic t_clear_full;
      int k;
      out_en_req = 1'b0;
      burst_mode = 1'b1;
      for (k = 0; k < DEPTH; k++) wr_word(4'(k), 1'b1);
      burst_mode = 1'b0;
      do_clear();
      out_en_req = 1'b1;
      no_read(30);
      wr_word(4'h3, 1'b1);
      rd_word(4'h3);
      $display("test clear_full done");
   endtask
   task automatic t_out_enable;
      out_en_req = 1'b0;
      wr_word(4'h9, 1'b1);
      tick(3);
      chk({7'h0, dev_out.out_enable}, 8'h0);
      no_read(20);
      chk({7'h0, orf}, 8'h1);
      out_en_req = 1'b1;
      rd_word(4'h9);
      $display("test out_enable done");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      tick(4);
      rst = 1'b0;
      tick(1);
      do_clear();
      $display("test start_clear done");
      t_fill_order();
      t_clear_full();
      t_out_enable();
      end_sim();
   end
endmodule // tb
`default_nettype wire
